// >>> hdl/sli_map.vh
// Overview of operation
// - supply select polarity picks optical channel
// - lamp one red: 1Hz external, 10Hz internal
// - lamp one green steady, 1Hz on weak
// - lamp two dark for idle interlock states
// - lamp two steady yellow when release possible
// - lamp two flashes while upstream circuit open
// - upstream changeover gives one or two flashes
// - lamp three dark without special function
// - lamp three steady blue after teach success
// - lamp three blue 1Hz while muting
// - short blue flashes for teach/restart/override
// - lamp three blue 10Hz on teach failure
`ifndef SLI_MAP_VH
`define SLI_MAP_VH
`define SLI_CLK_HZ        25000000
`define SLI_SLOW_HZ       1
`define SLI_FAST_HZ       10
`define SLI_YEL_HZ        2
`define SLI_SHORT_DIV     8
`define SLI_PULSE_MS      250
`define SLI_A_CTRL        12'h000
`define SLI_A_STAT        12'h004
`define SLI_A_ISTAT       12'h008
`define SLI_A_IMASK       12'h00C
`define SLI_C_OUT_ON      0
`define SLI_C_WEAK        1
`define SLI_C_EXT_ERR     2
`define SLI_C_INT_ERR     3
`define SLI_C_RI_EN       4
`define SLI_C_RI_BLOCK    5
`define SLI_C_FIELD_FREE  6
`define SLI_C_LINK_OK     7
`define SLI_C_UP_OPEN     8
`define SLI_C_TEACH_OK    9
`define SLI_C_MUTING      10
`define SLI_C_TEACHING    11
`define SLI_C_MUTE_RST    12
`define SLI_C_OVERRIDE    13
`define SLI_C_TEACH_FAIL  14
`define SLI_C_UP_CHG      15
`define SLI_C_UP_DOUBLE   16
`define SLI_CTRL_W        17
`define SLI_I_FAULT       0
`define SLI_I_CHAN        1
`define SLI_I_UP_CHG      2
`define SLI_I_TEACH_FAIL  3
`define SLI_I_W           4
`define SLI_COL_OFF       2'h0
`define SLI_COL_RED       2'h1
`define SLI_COL_GREEN     2'h2
`endif

// >>> hdl/sli_sync.v
`timescale 1ns/10ps
// three-stage synchroniser; change taken when stages two and three agree
module sli_sync
(
    input  wire hclk,      // clock
    input  wire hresetn,   // async reset, low
    input  wire din,       // asynchronous pin
    output reg  dout       // filtered level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout <= s3_q;
        end
    end
endmodule // sli_sync

// >>> hdl/sli_top.v
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "sli_map.vh"
module sli_top
#(
    parameter CLK_HZ = `SLI_CLK_HZ   // system clock rate
)
(
    input  wire        hclk,                 // bus clock
    input  wire        hresetn,              // async reset, low
    input  wire        hsel,                 // slave select
    input  wire [11:0] haddr,                // byte address
    input  wire [1:0]  htrans,               // transfer type
    input  wire        hwrite,               // write strobe
    input  wire [2:0]  hsize,                // transfer size
    input  wire        hready,               // bus ready in
    input  wire [31:0] hwdata,               // write data
    output reg  [31:0] hrdata,               // read data
    output reg         hreadyout,            // slave ready
    output reg         hresp,                // always okay
    input  wire        supply_select_a,      // wiring pin a
    input  wire        supply_select_b,      // wiring pin b
    output reg         optical_channel_one,  // channel one chosen
    output reg         optical_channel_two,  // channel two chosen
    output reg         lamp1_red,            // lamp one red
    output reg         lamp1_green,          // lamp one green
    output reg         lamp2_yellow,         // lamp two yellow
    output reg         lamp3_blue,           // lamp three blue
    output reg         irq                   // level interrupt
);
    localparam SLOW_HALF  = CLK_HZ / (2 * `SLI_SLOW_HZ);
    localparam FAST_HALF  = CLK_HZ / (2 * `SLI_FAST_HZ);
    localparam YEL_HALF   = CLK_HZ / (2 * `SLI_YEL_HZ);
    localparam CW         = 25;
    localparam ST_IDLE    = 2'h0;
    localparam ST_ON      = 2'h1;
    localparam ST_GAP     = 2'h2;

    // both wiring pins are asynchronous, so each gets its own filter
    wire       sel_a;
    wire       sel_b;
    wire [1:0] pin_raw;
    wire [1:0] pin_sync;
    genvar     gi;
    assign pin_raw = {supply_select_b, supply_select_a};
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_sync
            sli_sync u_sync
            (
                .hclk    (hclk),
                .hresetn (hresetn),
                .din     (pin_raw[gi]),
                .dout    (pin_sync[gi])
            );
        end
    endgenerate
    assign sel_a = pin_sync[0];
    assign sel_b = pin_sync[1];

    // bus slave: capture address phase, act in data phase
    reg                    ap_wr_q;
    reg [11:0]             ap_addr_q;
    reg [`SLI_CTRL_W-1:0]  ctrl_q;
    reg [`SLI_I_W-1:0]     istat_q;
    reg [`SLI_I_W-1:0]     imask_q;
    reg [`SLI_I_W-1:0]     ev_d;
    wire                   take = hsel & hready & htrans[1];

    function hit;
        input [11:0] a;
        input [11:0] b;
        hit = (a[11:2] == b[11:2]);
    endfunction

    // flash generators
    reg [CW-1:0] slow_cnt_q;
    reg [CW-1:0] fast_cnt_q;
    reg [CW-1:0] yel_cnt_q;
    reg          slow_q;
    reg          fast_q;
    reg          yel_q;
    reg [2:0]    short_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            slow_cnt_q <= {CW{1'b0}};
            fast_cnt_q <= {CW{1'b0}};
            yel_cnt_q  <= {CW{1'b0}};
            slow_q     <= 1'b0;
            fast_q     <= 1'b0;
            yel_q      <= 1'b0;
            short_q    <= 3'h0;
        end
        else
        begin
            if (slow_cnt_q == SLOW_HALF[CW-1:0] - 1'b1)
            begin
                slow_cnt_q <= {CW{1'b0}};
                slow_q     <= ~slow_q;
            end
            else
                slow_cnt_q <= slow_cnt_q + 1'b1;
            if (fast_cnt_q == FAST_HALF[CW-1:0] - 1'b1)
            begin
                fast_cnt_q <= {CW{1'b0}};
                fast_q     <= ~fast_q;
                short_q    <= short_q + 3'h1;
            end
            else
                fast_cnt_q <= fast_cnt_q + 1'b1;
            if (yel_cnt_q == YEL_HALF[CW-1:0] - 1'b1)
            begin
                yel_cnt_q <= {CW{1'b0}};
                yel_q     <= ~yel_q;
            end
            else
                yel_cnt_q <= yel_cnt_q + 1'b1;
        end
    end
    // short flash: one fast half-period lit out of eight
    wire short_on = (short_q == 3'h0);

    // changeover flash sequencer: one or two yellow pulses
    reg [1:0]    up_st_q;
    reg [1:0]    up_left_q;
    reg [CW-1:0] up_cnt_q;
    reg          chg_prev_q;
    wire         chg_rise = ctrl_q[`SLI_C_UP_CHG] & ~chg_prev_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            up_st_q    <= ST_IDLE;
            up_left_q  <= 2'h0;
            up_cnt_q   <= {CW{1'b0}};
            chg_prev_q <= 1'b0;
        end
        else
        begin
            chg_prev_q <= ctrl_q[`SLI_C_UP_CHG];
            case (up_st_q)
                ST_IDLE:
                    if (chg_rise)
                    begin
                        up_st_q   <= ST_ON;
                        up_left_q <= ctrl_q[`SLI_C_UP_DOUBLE] ? 2'h2 : 2'h1;
                        up_cnt_q  <= {CW{1'b0}};
                    end
                ST_ON:
                    if (up_cnt_q == YEL_HALF[CW-1:0] - 1'b1)
                    begin
                        up_cnt_q  <= {CW{1'b0}};
                        up_left_q <= up_left_q - 2'h1;
                        up_st_q   <= ST_GAP;
                    end
                    else
                        up_cnt_q <= up_cnt_q + 1'b1;
                ST_GAP:
                    if (up_cnt_q == YEL_HALF[CW-1:0] - 1'b1)
                    begin
                        up_cnt_q <= {CW{1'b0}};
                        up_st_q  <= (up_left_q == 2'h0) ? ST_IDLE : ST_ON;
                    end
                    else
                        up_cnt_q <= up_cnt_q + 1'b1;
                default:
                    up_st_q <= ST_IDLE;
            endcase
        end
    end

    // lamp decode, fixed priority per lamp
    reg [1:0] l1_d;
    reg       l2_d;
    reg       l3_d;
    always @*
    begin
        if (ctrl_q[`SLI_C_INT_ERR])
            l1_d = fast_q ? `SLI_COL_RED : `SLI_COL_OFF;
        else if (ctrl_q[`SLI_C_EXT_ERR])
            l1_d = slow_q ? `SLI_COL_RED : `SLI_COL_OFF;
        else if (!ctrl_q[`SLI_C_OUT_ON])
            l1_d = `SLI_COL_RED;
        else if (ctrl_q[`SLI_C_WEAK])
            l1_d = slow_q ? `SLI_COL_GREEN : `SLI_COL_OFF;
        else
            l1_d = `SLI_COL_GREEN;
        if (up_st_q != ST_IDLE)
            l2_d = (up_st_q == ST_ON);
        else if (ctrl_q[`SLI_C_UP_OPEN])
            l2_d = yel_q;
        else if (ctrl_q[`SLI_C_RI_EN] & ctrl_q[`SLI_C_RI_BLOCK]
                 & ctrl_q[`SLI_C_FIELD_FREE] & ctrl_q[`SLI_C_LINK_OK])
            l2_d = 1'b1;
        else
            l2_d = 1'b0;
        if (ctrl_q[`SLI_C_TEACH_FAIL])
            l3_d = fast_q;
        else if (ctrl_q[`SLI_C_TEACHING] | ctrl_q[`SLI_C_MUTE_RST]
                 | ctrl_q[`SLI_C_OVERRIDE])
            l3_d = short_on;
        else if (ctrl_q[`SLI_C_MUTING])
            l3_d = slow_q;
        else if (ctrl_q[`SLI_C_TEACH_OK])
            l3_d = 1'b1;
        else
            l3_d = 1'b0;
    end

    // channel: only the two legal polarities change the choice
    reg ch1_d;
    reg ch2_d;
    always @*
    begin
        ch1_d = optical_channel_one;
        ch2_d = optical_channel_two;
        if (sel_a & ~sel_b)
        begin
            ch1_d = 1'b1;
            ch2_d = 1'b0;
        end
        else if (~sel_a & sel_b)
        begin
            ch1_d = 1'b0;
            ch2_d = 1'b1;
        end
    end

    reg fault_prev_q;
    reg l3_prev_fail_q;
    wire fault_now = ctrl_q[`SLI_C_INT_ERR] | ctrl_q[`SLI_C_EXT_ERR];
    always @*
    begin
        ev_d = {`SLI_I_W{1'b0}};
        ev_d[`SLI_I_FAULT]      = fault_now & ~fault_prev_q;
        // either output moving counts, so a first pick of channel two is seen too
        ev_d[`SLI_I_CHAN]       = (ch1_d != optical_channel_one)
                                  | (ch2_d != optical_channel_two);
        ev_d[`SLI_I_UP_CHG]     = chg_rise;
        ev_d[`SLI_I_TEACH_FAIL] = ctrl_q[`SLI_C_TEACH_FAIL] & ~l3_prev_fail_q;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_wr_q             <= 1'b0;
            ap_addr_q           <= 12'h000;
            ctrl_q              <= {`SLI_CTRL_W{1'b0}};
            istat_q             <= {`SLI_I_W{1'b0}};
            imask_q             <= {`SLI_I_W{1'b0}};
            hrdata              <= 32'h00000000;
            hreadyout           <= 1'b1;
            hresp               <= 1'b0;
            optical_channel_one <= 1'b0;
            optical_channel_two <= 1'b0;
            lamp1_red           <= 1'b0;
            lamp1_green         <= 1'b0;
            lamp2_yellow        <= 1'b0;
            lamp3_blue          <= 1'b0;
            irq                 <= 1'b0;
            fault_prev_q        <= 1'b0;
            l3_prev_fail_q      <= 1'b0;
        end
        else
        begin
            fault_prev_q   <= fault_now;
            l3_prev_fail_q <= ctrl_q[`SLI_C_TEACH_FAIL];
            ap_wr_q        <= take & hwrite;
            if (take)
                ap_addr_q <= haddr;
            if (ap_wr_q & hit(ap_addr_q, `SLI_A_CTRL))
                ctrl_q <= hwdata[`SLI_CTRL_W-1:0];
            if (ap_wr_q & hit(ap_addr_q, `SLI_A_IMASK))
                imask_q <= hwdata[`SLI_I_W-1:0];
            // a new event wins over a write-one clear in the same cycle
            if (ap_wr_q & hit(ap_addr_q, `SLI_A_ISTAT))
                istat_q <= (istat_q & ~hwdata[`SLI_I_W-1:0]) | ev_d;
            else
                istat_q <= istat_q | ev_d;
            // read data is registered, so the address is decoded straight off haddr
            if (take & ~hwrite)
            begin
                if (hit(haddr, `SLI_A_CTRL))
                    hrdata <= {{(32-`SLI_CTRL_W){1'b0}}, ctrl_q};
                else if (hit(haddr, `SLI_A_STAT))
                    hrdata <= {24'h000000, optical_channel_two, optical_channel_one,
                               lamp3_blue, lamp2_yellow, lamp1_green, lamp1_red,
                               sel_b, sel_a};
                else if (hit(haddr, `SLI_A_ISTAT))
                    hrdata <= {{(32-`SLI_I_W){1'b0}}, istat_q};
                else if (hit(haddr, `SLI_A_IMASK))
                    hrdata <= {{(32-`SLI_I_W){1'b0}}, imask_q};
                else
                    hrdata <= 32'h00000000;
            end
            optical_channel_one <= ch1_d;
            optical_channel_two <= ch2_d;
            lamp1_red    <= (l1_d == `SLI_COL_RED);
            lamp1_green  <= (l1_d == `SLI_COL_GREEN);
            lamp2_yellow <= l2_d;
            lamp3_blue   <= l3_d;
            irq          <= |(istat_q & imask_q);
        end
    end
endmodule // sli_top

// >>> bench/sli_wiring.sv
`timescale 1ns/10ps
module sli_wiring
(
    input  wire       hclk,             // bench clock
    input  wire [1:0] pol,              // wanted levels {a,b}
    output reg        supply_select_a,  // wiring pin a
    output reg        supply_select_b   // wiring pin b
);
    // hard-wired pins: levels only move when the bench rewires them
    initial
    begin
        supply_select_a = 1'b0;
        supply_select_b = 1'b0;
    end
    always @(posedge hclk)
    begin
        supply_select_a <= pol[1];
        supply_select_b <= pol[0];
    end
endmodule // sli_wiring

// >>> bench/sli_top_properties.sv
`timescale 1ns/10ps
`include "sli_map.vh"
module sli_top_properties
#(
    parameter CLK_HZ = `SLI_CLK_HZ  // flash time base
)
(
    input wire        hclk,                 // clock
    input wire        hresetn,              // reset, low
    input wire        hsel,                 // select
    input wire [11:0] haddr,                // address
    input wire [1:0]  htrans,               // transfer
    input wire        hwrite,               // write
    input wire        hready,               // ready in
    input wire [31:0] hwdata,               // write data
    input wire        hreadyout,            // ready out
    input wire        hresp,                // response
    input wire        supply_select_a,      // pin a
    input wire        supply_select_b,      // pin b
    input wire        optical_channel_one,  // channel one
    input wire        optical_channel_two,  // channel two
    input wire        lamp1_red,            // red
    input wire        lamp1_green,          // green
    input wire        lamp2_yellow,         // yellow
    input wire        lamp3_blue            // blue
);
    localparam int FAST_HALF = CLK_HZ / 20;
    reg         wr_q;
    reg  [11:0] adr_q;
    reg  [16:0] ctrl_q;
    reg         red_q;
    reg  [31:0] red_age_q;
    reg  [31:0] err_age_q;
    // shadow of the control word, so lamp checks need no internals
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q      <= 1'b0;
            adr_q     <= 12'h000;
            ctrl_q    <= 17'h00000;
            red_q     <= 1'b0;
            red_age_q <= 32'h00000000;
            err_age_q <= 32'h00000000;
        end
        else
        begin
            wr_q      <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
                adr_q <= haddr;
            if (wr_q && adr_q == `SLI_A_CTRL)
                ctrl_q <= hwdata[16:0];
            red_q     <= lamp1_red;
            red_age_q <= (red_q != lamp1_red) ? 32'h00000000 : red_age_q + 32'h00000001;
            err_age_q <= ctrl_q[3] ? err_age_q + 32'h00000001 : 32'h00000000;
        end
    end
    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_CH_ONE: assert property
        ((supply_select_a && !supply_select_b)[*8] |-> optical_channel_one)
        else $error("channel one not selected");
    AST_CH_TWO: assert property
        ((!supply_select_a && supply_select_b)[*8] |-> optical_channel_two)
        else $error("channel two not selected");
    AST_CH_EXCL: assert property (!(optical_channel_one && optical_channel_two))
        else $error("both channels selected");
    AST_L1_OFF: assert property ((ctrl_q[3:0] == 4'h0)[*3] |-> lamp1_red && !lamp1_green)
        else $error("lamp one not steady red");
    AST_L1_ON: assert property ((ctrl_q[3:0] == 4'h1)[*3] |-> lamp1_green && !lamp1_red)
        else $error("lamp one not steady green");
    AST_L1_ERR: assert property ((ctrl_q[3:2] != 2'h0)[*3] |-> !lamp1_green)
        else $error("green shown during a fault");
    AST_L1_FAST: assert property (err_age_q > FAST_HALF + 3 |-> red_age_q <= FAST_HALF + 1)
        else $error("red too slow for internal fault");
    AST_L3_DARK: assert property ((ctrl_q[14:9] == 6'h00)[*3] |-> !lamp3_blue)
        else $error("blue lit without function");
    AST_L3_TEACH: assert property ((ctrl_q[14:9] == 6'h01)[*3] |-> lamp3_blue)
        else $error("blue not steady after teach");
    AST_BUS: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    cover property (err_age_q > FAST_HALF + 3);
    cover property (ctrl_q[15] && lamp2_yellow);
    cover property (optical_channel_two);
endmodule // sli_top_properties
bind sli_top sli_top_properties #(.CLK_HZ(CLK_HZ)) u_props
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .supply_select_a(supply_select_a), .supply_select_b(supply_select_b),
    .optical_channel_one(optical_channel_one), .optical_channel_two(optical_channel_two),
    .lamp1_red(lamp1_red), .lamp1_green(lamp1_green), .lamp2_yellow(lamp2_yellow),
    .lamp3_blue(lamp3_blue)
);

// >>> bench/test_status_led_indicator.sv
`timescale 1ns/10ps
`include "sli_map.vh"
module test_status_led_indicator;
    reg         hclk;
    reg         hresetn = 1'b0;
    reg         hsel    = 1'b0;
    reg  [11:0] haddr   = 12'h000;
    reg  [1:0]  htrans  = 2'h0;
    reg         hwrite  = 1'b0;
    reg  [2:0]  hsize   = 3'h2;
    reg  [31:0] hwdata  = 32'h00000000;
    reg  [1:0]  pol     = 2'h0;
    reg  [31:0] rd;
    integer     err_count = 0;
    integer     compares  = 0;
    integer     k;
    integer     m;
    integer     r;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        supply_select_a;
    wire        supply_select_b;
    wire        irq;
    wire [3:0]  lamps;
    sli_top #(.CLK_HZ(200)) dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .supply_select_a(supply_select_a),
        .supply_select_b(supply_select_b), .optical_channel_one(), .optical_channel_two(),
        .lamp1_red(lamps[0]), .lamp1_green(lamps[1]), .lamp2_yellow(lamps[2]),
        .lamp3_blue(lamps[3]), .irq(irq)
    );
    sli_wiring u_wiring
    (
        .hclk(hclk), .pol(pol), .supply_select_a(supply_select_a),
        .supply_select_b(supply_select_b)
    );
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d);
    begin
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    end
    endtask
    task rdchk(input [11:0] a, input [31:0] e);
    begin
        bus(1'b0, a, 32'h00000000);
        chk(rd, e);
    end
    endtask
    // high and low run lengths of one lamp; 300 stands for steady
    task lamp(input [1:0] i, input [16:0] c, input integer hi, input integer lo);
        integer h;
        integer l;
        integer n;
    begin
        bus(1'b1, `SLI_A_CTRL, {15'h0000, c});
        @(negedge hclk);
        for (n = 0; n < 300 && lamps[i] !== 1'b0; n = n + 1) @(negedge hclk);
        for (n = 0; n < 300 && lamps[i] !== 1'b1; n = n + 1) @(negedge hclk);
        for (h = 0; h < 300 && lamps[i] === 1'b1; h = h + 1) @(negedge hclk);
        for (l = 0; l < 300 && lamps[i] === 1'b0; l = l + 1) @(negedge hclk);
        chk(h, hi);
        chk(l, lo);
        @(posedge hclk);
    end
    endtask
    task close_out;
    begin
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(`SLI_A_CTRL, 32'h00000000);
        rdchk(`SLI_A_STAT, 32'h00000004);
        rdchk(`SLI_A_ISTAT, 32'h00000000);
        rdchk(`SLI_A_IMASK, 32'h00000000);
        rdchk(12'h010, 32'h00000000);
        $display("test reset values done");
        pol <= 2'h2;
        repeat (8) @(posedge hclk);
        rdchk(`SLI_A_STAT, 32'h00000045);
        chk(irq, 1'b0);
        bus(1'b1, `SLI_A_IMASK, 32'h00000002);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b1);
        bus(1'b1, `SLI_A_ISTAT, 32'h00000002);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b0);
        pol <= 2'h1;
        repeat (8) @(posedge hclk);
        rdchk(`SLI_A_STAT, 32'h00000086);
        pol <= 2'h3;
        repeat (8) @(posedge hclk);
        rdchk(`SLI_A_STAT, 32'h00000087);
        chk(irq, 1'b1);
        bus(1'b1, `SLI_A_ISTAT, 32'h0000000F);
        $display("test channel done");
        lamp(2'h0, 17'h00000, 300, 0);
        lamp(2'h0, 17'h00004, 100, 100);
        lamp(2'h0, 17'h00008, 10, 10);
        lamp(2'h0, 17'h0000D, 10, 10);
        lamp(2'h1, 17'h0000D, 0, 300);
        lamp(2'h1, 17'h00001, 300, 0);
        lamp(2'h1, 17'h00003, 100, 100);
        lamp(2'h2, 17'h00030, 0, 300);
        lamp(2'h2, 17'h000F0, 300, 0);
        lamp(2'h2, 17'h001F0, 50, 50);
        lamp(2'h3, 17'h00000, 0, 300);
        lamp(2'h3, 17'h00200, 300, 0);
        lamp(2'h3, 17'h00600, 100, 100);
        lamp(2'h3, 17'h00800, 10, 70);
        lamp(2'h3, 17'h01000, 10, 70);
        lamp(2'h3, 17'h02000, 10, 70);
        lamp(2'h3, 17'h04C00, 10, 10);
        $display("test lamps done");
        for (k = 1; k <= 2; k = k + 1)
        begin
            bus(1'b1, `SLI_A_CTRL, 32'h00000000);
            bus(1'b1, `SLI_A_CTRL, (k == 2) ? 32'h00018000 : 32'h00008000);
            r = 0;
            for (m = 0; m < 400; m = m + 1)
            begin
                @(negedge hclk);
                r = r + lamps[2];
            end
            @(posedge hclk);
            chk(r, 50 * k);
        end
        rdchk(`SLI_A_ISTAT, 32'h0000000D);
        rdchk(`SLI_A_CTRL, 32'h00018000);
        $display("test changeover done");
        close_out;
    end
    initial
    begin
        repeat (60000) @(posedge hclk);
        err_count = err_count + 1;
        close_out;
    end
endmodule // test_status_led_indicator
